// ### logic/dual_fifo.sv
// top of the dual-port fifo: port a writes, port b reads, mailboxes
// both ways, programmable thresholds, apb registers and interrupt.
// assumes port pins are synchronous to i_clock and port clocks run
// below half its rate; port edges are found by sampling.
//
// How it works
// - a 1024 word by 36 bit store, written at port a, read in order at b
// - transfers only on a qualified rising edge of the port's own clock
// - port clocks may be unrelated or identical; no relation is assumed
// - input-ready and almost-full pass two stages stepped by port a clock
// - output-ready and almost-empty pass two stages stepped by port b clock
// - almost-empty low while stored words at or below almost-empty offset
// - almost-full low while free locations at or below almost-full offset
// - full and empty indications besides the threshold flags
// - two 36 bit mailboxes, one each direction, outside the store
// - each mailbox has a new-mail flag for the receiving port
// - retransmit lets words already read at port b be read again
// - offsets load by port a words or bit by bit on a serial input
// - each port is a 36 bit two-way data bus
// - input-ready low when full or at retransmit point, low in reset
// - serial load takes 20 bits, almost-full msb first, almost-empty lsb last
// - straps at reset pick preset, parallel or serial offset loading
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dual_fifo
	import dual_fifo_pkg::*;
(
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst,
	// port a
	input  wire logic                  i_write_side_clock,
	input  wire logic                  i_side_a_select_n,
	input  wire logic                  i_side_a_master_enable,
	input  wire logic                  i_side_a_write,
	input  wire logic                  i_side_a_mailbox_select,
	input  wire logic [DATA_W-1:0]     i_side_a_data_bus,
	output logic      [DATA_W-1:0]     o_side_a_data_bus,
	output logic                       o_side_a_data_bus_oe,
	output logic                       o_input_ready_flag,
	output logic                       o_almost_full_flag_n,
	output logic                       o_mail_to_a_waiting,
	// port b
	input  wire logic                  i_read_side_clock,
	input  wire logic                  i_side_b_select_n,
	input  wire logic                  i_side_b_master_enable,
	input  wire logic                  i_side_b_write,
	input  wire logic                  i_side_b_mailbox_select,
	input  wire logic [DATA_W-1:0]     i_side_b_data_bus,
	output logic      [DATA_W-1:0]     o_side_b_data_bus,
	output logic                       o_side_b_data_bus_oe,
	output logic                       o_output_ready_flag,
	output logic                       o_almost_empty_flag_n,
	output logic                       o_mail_to_b_waiting,
	// offset straps and serial load
	input  wire logic                  i_offset_select_hi_serial_enable,
	input  wire logic                  i_offset_select_lo_serial_bit,
	// store status
	output logic                       o_store_full,
	output logic                       o_store_empty,
	// apb slave
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [APB_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	output logic                       o_irq
);

	function automatic logic port_go(input logic edge_seen, input logic sel_n,
	                                 input logic enable);
		port_go = edge_seen & ~sel_n & enable;
	endfunction

	// ****************************************
	// port edges and transfer decode
	// ****************************************
	logic              a_clock_prev, b_clock_prev;
	logic              a_edge, b_edge, a_go, b_go;
	logic [PTR_W-1:0]  wr_ptr, rd_ptr, mark;
	logic [PTR_W-1:0]  stored, free;
	logic              raw_full, raw_empty;
	logic [OFFSET_W-1:0] x_offset, y_offset;
	logic              rt_mode;
	logic              a_fifo_write, a_offset_write, a_mail_write, a_mail_read;
	logic              b_fifo_read, b_mail_write, b_mail_read;
	logic [DATA_W-1:0] store_data;
	cfg_e              cfg_state;

	// sampling both port clocks with one clock needs them below half its rate
	assign a_edge = i_write_side_clock & ~a_clock_prev;
	assign b_edge = i_read_side_clock & ~b_clock_prev;
	assign a_go   = port_go(a_edge, i_side_a_select_n, i_side_a_master_enable);
	assign b_go   = port_go(b_edge, i_side_b_select_n, i_side_b_master_enable);

	assign stored    = wr_ptr - rd_ptr;
	// in retransmit mode words from the mark onward may not be overwritten
	assign free      = DEPTH_CNT - (wr_ptr - (rt_mode ? mark : rd_ptr));
	assign raw_full  = (free == '0);
	assign raw_empty = (stored == '0);

	assign a_mail_write   = a_go & i_side_a_write & i_side_a_mailbox_select;
	assign a_mail_read    = a_go & ~i_side_a_write & i_side_a_mailbox_select;
	assign a_offset_write = a_go & i_side_a_write & ~i_side_a_mailbox_select
	                      & (cfg_state == CFG_LOAD_X || cfg_state == CFG_LOAD_Y);
	// raw full also gates, since the flag clears one cycle late
	assign a_fifo_write   = a_go & i_side_a_write & ~i_side_a_mailbox_select
	                      & o_input_ready_flag & ~raw_full;
	assign b_mail_write   = b_go & i_side_b_write & i_side_b_mailbox_select;
	assign b_mail_read    = b_go & ~i_side_b_write & i_side_b_mailbox_select;
	assign b_fifo_read    = b_go & ~i_side_b_write & ~i_side_b_mailbox_select
	                      & o_output_ready_flag & ~raw_empty;

	dual_fifo_store u_store (
		.i_clock      (i_clock),
		.i_write      (a_fifo_write),
		.i_write_addr (wr_ptr[ADDR_W-1:0]),
		.i_write_data (i_side_a_data_bus),
		.i_read_addr  (rd_ptr[ADDR_W-1:0]),
		.o_read_data  (store_data)
	);

	// ****************************************
	// flags
	// ****************************************
	flag_sync #(.RESET_VALUE(1'b0)) u_ready_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_step  (a_edge),
		.i_level ((cfg_state == CFG_DONE) & ~raw_full),
		.o_level (o_input_ready_flag)
	);

	flag_sync #(.RESET_VALUE(1'b1)) u_afull_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_step  (a_edge),
		.i_level (free > {1'b0, y_offset}),
		.o_level (o_almost_full_flag_n)
	);

	flag_sync #(.RESET_VALUE(1'b0)) u_out_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_step  (b_edge),
		.i_level (~raw_empty),
		.o_level (o_output_ready_flag)
	);

	flag_sync #(.RESET_VALUE(1'b0)) u_aempty_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_step  (b_edge),
		.i_level (stored > {1'b0, x_offset}),
		.o_level (o_almost_empty_flag_n)
	);

	// ****************************************
	// store, offsets, mailboxes, data buses
	// ****************************************
	logic                rt_restart, mark_load;
	logic [4:0]          serial_count, next_serial_count;
	logic [PTR_W-1:0]    next_wr_ptr, next_rd_ptr, next_mark;
	logic [OFFSET_W-1:0] next_x_offset, next_y_offset;
	logic [DATA_W-1:0]   mail_to_b, mail_to_a, next_mail_to_b, next_mail_to_a;
	logic [DATA_W-1:0]   next_a_bus, next_b_bus;
	cfg_e                next_cfg_state;

	always_comb begin
		next_cfg_state    = cfg_state;
		next_x_offset     = x_offset;
		next_y_offset     = y_offset;
		next_serial_count = serial_count;
		next_wr_ptr       = a_fifo_write ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr       = b_fifo_read ? rd_ptr + 1'b1 : rd_ptr;
		next_mark         = mark_load ? rd_ptr : mark;
		if (rt_restart) begin
			next_rd_ptr = mark;
		end
		case (cfg_state)
			// straps are taken in the first cycle after reset release
			CFG_STRAP: begin
				case ({i_offset_select_hi_serial_enable, i_offset_select_lo_serial_bit})
					STRAP_PARALLEL:  next_cfg_state = CFG_LOAD_X;
					STRAP_SERIAL:    next_cfg_state = CFG_SERIAL;
					STRAP_PRESET_HI: begin
						next_x_offset  = PRESET_HI;
						next_y_offset  = PRESET_HI;
						next_cfg_state = CFG_DONE;
					end
					default: begin
						next_x_offset  = PRESET_LO;
						next_y_offset  = PRESET_LO;
						next_cfg_state = CFG_DONE;
					end
				endcase
			end
			CFG_LOAD_X: begin
				if (a_offset_write) begin
					next_x_offset  = i_side_a_data_bus[OFFSET_W-1:0];
					next_cfg_state = CFG_LOAD_Y;
				end
			end
			CFG_LOAD_Y: begin
				if (a_offset_write) begin
					next_y_offset  = i_side_a_data_bus[OFFSET_W-1:0];
					next_cfg_state = CFG_DONE;
				end
			end
			CFG_SERIAL: begin
				if (a_edge && !i_offset_select_hi_serial_enable) begin
					{next_y_offset, next_x_offset} = {y_offset[OFFSET_W-2:0], x_offset,
					                                  i_offset_select_lo_serial_bit};
					next_serial_count = serial_count + 1'b1;
					if (serial_count == SERIAL_LAST) begin
						next_cfg_state = CFG_DONE;
					end
				end
			end
			default: next_cfg_state = CFG_DONE;
		endcase
		next_mail_to_b = a_mail_write ? i_side_a_data_bus : mail_to_b;
		next_mail_to_a = b_mail_write ? i_side_b_data_bus : mail_to_a;
		next_a_bus     = a_mail_read ? mail_to_a : o_side_a_data_bus;
		next_b_bus     = o_side_b_data_bus;
		if (b_mail_read) begin
			next_b_bus = mail_to_b;
		end else if (b_fifo_read) begin
			next_b_bus = store_data;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			// high, so a port clock already high at release is not taken as an edge
			a_clock_prev          <= 1'b1;
			b_clock_prev          <= 1'b1;
			cfg_state             <= CFG_STRAP;
			x_offset              <= '0;
			y_offset              <= '0;
			serial_count          <= '0;
			wr_ptr                <= '0;
			rd_ptr                <= '0;
			mark                  <= '0;
			mail_to_b             <= '0;
			mail_to_a             <= '0;
			o_mail_to_b_waiting   <= 1'b0;
			o_mail_to_a_waiting   <= 1'b0;
			o_side_a_data_bus     <= '0;
			o_side_b_data_bus     <= '0;
			o_side_a_data_bus_oe  <= 1'b0;
			o_side_b_data_bus_oe  <= 1'b0;
			o_store_full          <= 1'b0;
			o_store_empty         <= 1'b1;
		end else begin
			a_clock_prev          <= i_write_side_clock;
			b_clock_prev          <= i_read_side_clock;
			cfg_state             <= next_cfg_state;
			x_offset              <= next_x_offset;
			y_offset              <= next_y_offset;
			serial_count          <= next_serial_count;
			wr_ptr                <= next_wr_ptr;
			rd_ptr                <= next_rd_ptr;
			mark                  <= next_mark;
			mail_to_b             <= next_mail_to_b;
			mail_to_a             <= next_mail_to_a;
			// new mail wins over a read in the same cycle
			o_mail_to_b_waiting   <= (o_mail_to_b_waiting & ~b_mail_read) | a_mail_write;
			o_mail_to_a_waiting   <= (o_mail_to_a_waiting & ~a_mail_read) | b_mail_write;
			o_side_a_data_bus     <= next_a_bus;
			o_side_b_data_bus     <= next_b_bus;
			o_side_a_data_bus_oe  <= ~i_side_a_select_n & ~i_side_a_write;
			o_side_b_data_bus_oe  <= ~i_side_b_select_n & ~i_side_b_write;
			o_store_full          <= raw_full;
			o_store_empty         <= raw_empty;
		end
	end

	// ****************************************
	// apb registers and interrupt
	// ****************************************
	logic             setup, bus_write;
	logic [IRQ_W-1:0] irq_status, irq_mask, events;
	logic [IRQ_W-1:0] next_irq_status, next_irq_mask;
	logic [31:0]      next_prdata;
	logic             next_pslverr, next_rt_mode;

	assign setup      = i_psel & ~i_penable;
	assign bus_write  = i_psel & i_penable & o_pready & i_pwrite;
	assign rt_restart = bus_write && i_paddr == REG_CONTROL && i_pwdata[CTRL_RT_RESTART];
	assign mark_load  = bus_write && i_paddr == REG_CONTROL && i_pwdata[CTRL_RT_MODE] && !rt_mode;

	always_comb begin
		events                = '0;
		events[IRQ_MAIL_TO_B] = a_mail_write;
		events[IRQ_MAIL_TO_A] = b_mail_write;
		events[IRQ_FULL]      = raw_full & ~o_store_full;
		events[IRQ_EMPTY]     = raw_empty & ~o_store_empty;
		next_rt_mode          = rt_mode;
		next_irq_mask         = irq_mask;
		next_irq_status       = irq_status;
		if (bus_write && i_paddr == REG_CONTROL) begin
			next_rt_mode = i_pwdata[CTRL_RT_MODE];
		end
		if (bus_write && i_paddr == REG_IRQ_MASK) begin
			next_irq_mask = i_pwdata[IRQ_W-1:0];
		end
		if (bus_write && i_paddr == REG_IRQ_STATUS) begin
			next_irq_status = irq_status & ~i_pwdata[IRQ_W-1:0];
		end
		// a new event wins over a clear in the same cycle
		next_irq_status = next_irq_status | events;
		next_pslverr    = 1'b0;
		next_prdata     = o_prdata;
		if (setup) begin
			next_prdata = '0;
			case (i_paddr)
				REG_CONTROL:    next_prdata[CTRL_RT_MODE] = rt_mode;
				REG_STATE: begin
					next_prdata[7:0] = {o_mail_to_a_waiting, o_mail_to_b_waiting,
					                    o_store_empty, o_store_full,
					                    o_almost_empty_flag_n, o_almost_full_flag_n,
					                    o_output_ready_flag, o_input_ready_flag};
					next_prdata[STATE_COUNT_LSB +: PTR_W] = stored;
				end
				REG_IRQ_STATUS: next_prdata[IRQ_W-1:0] = irq_status;
				REG_IRQ_MASK:   next_prdata[IRQ_W-1:0] = irq_mask;
				REG_OFFSETS: begin
					next_prdata[OFFSET_W-1:0]                 = x_offset;
					next_prdata[OFFSETS_Y_LSB +: OFFSET_W]    = y_offset;
				end
				default:        next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_pready   <= 1'b0;
			o_pslverr  <= 1'b0;
			o_prdata   <= '0;
			rt_mode    <= 1'b0;
			irq_status <= '0;
			irq_mask   <= '0;
			o_irq      <= 1'b0;
		end else begin
			o_pready   <= setup;
			o_pslverr  <= next_pslverr;
			o_prdata   <= next_prdata;
			rt_mode    <= next_rt_mode;
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			o_irq      <= |(next_irq_status & next_irq_mask);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_write_advances;
		a_fifo_write |=> wr_ptr == $past(wr_ptr) + 11'h001;
	endproperty
	a_write_advances: assert property (p_write_advances) else $error("write did not advance");

	property p_full_drops_ready;
		raw_full |=> !o_input_ready_flag && !a_fifo_write;
	endproperty
	a_full_drops_ready: assert property (p_full_drops_ready) else $error("ready high when full");

	property p_ready_rise_on_a;
		$rose(o_input_ready_flag) |-> $past(a_edge);
	endproperty
	a_ready_rise_on_a: assert property (p_ready_rise_on_a) else $error("ready rose off port a");

	property p_out_rise_on_b;
		$rose(o_output_ready_flag) |-> $past(b_edge) && !raw_empty;
	endproperty
	a_out_rise_on_b: assert property (p_out_rise_on_b) else $error("output ready rose badly");

	property p_empty_drops_out;
		raw_empty |=> !o_output_ready_flag ##0 !b_fifo_read;
	endproperty
	a_empty_drops_out: assert property (p_empty_drops_out) else $error("output ready while empty");

	property p_almost_empty;
		stored <= {1'b0, x_offset} |=> !o_almost_empty_flag_n;
	endproperty
	a_almost_empty: assert property (p_almost_empty) else $error("almost empty not low");

	property p_almost_full;
		free <= {1'b0, y_offset} |=> !o_almost_full_flag_n;
	endproperty
	a_almost_full: assert property (p_almost_full) else $error("almost full not low");

	property p_mail_flag;
		a_mail_write |=> o_mail_to_b_waiting && mail_to_b == $past(i_side_a_data_bus);
	endproperty
	a_mail_flag: assert property (p_mail_flag) else $error("mail flag not raised");

	property p_restart;
		rt_restart |=> rd_ptr == $past(mark);
	endproperty
	a_restart: assert property (p_restart) else $error("retransmit did not rewind");

	property p_serial_end;
		cfg_state == CFG_SERIAL && serial_count == SERIAL_LAST
		&& a_edge && !i_offset_select_hi_serial_enable |=> cfg_state == CFG_DONE;
	endproperty
	a_serial_end: assert property (p_serial_end) else $error("serial load not done at 20");

	property p_float;
		i_side_a_select_n |=> !o_side_a_data_bus_oe;
	endproperty
	a_float: assert property (p_float) else $error("port a driven unselected");

endmodule

`default_nettype wire

// ### logic/dual_fifo_pkg.sv
// shared constants for the dual-port fifo block: store geometry,
// offset programming, register map and field positions.
// assumes every module of the block but flag_sync imports it whole.
`default_nettype none

package dual_fifo_pkg;

	// ****************************************
	// store geometry
	// ****************************************
	localparam int                DATA_W     = 36;
	localparam int                ADDR_W     = 10;
	localparam int                PTR_W      = 11;
	localparam int                DEPTH      = 1024;
	localparam logic [PTR_W-1:0]  DEPTH_CNT  = 11'h400;
	localparam int                OFFSET_W   = 10;
	localparam logic [4:0]        SERIAL_LAST = 5'h13;

	// ****************************************
	// offset programming
	// ****************************************
	localparam logic [1:0]          STRAP_PARALLEL  = 2'h0;
	localparam logic [1:0]          STRAP_PRESET_HI = 2'h1;
	localparam logic [1:0]          STRAP_PRESET_LO = 2'h2;
	localparam logic [1:0]          STRAP_SERIAL    = 2'h3;
	localparam logic [OFFSET_W-1:0] PRESET_LO       = 10'h008;
	localparam logic [OFFSET_W-1:0] PRESET_HI       = 10'h020;

	typedef enum logic [2:0] {
		CFG_STRAP,
		CFG_LOAD_X,
		CFG_LOAD_Y,
		CFG_SERIAL,
		CFG_DONE
	} cfg_e;

	// ****************************************
	// register map
	// ****************************************
	localparam int         APB_ADDR_W     = 8;
	localparam logic [7:0] REG_CONTROL    = 8'h00;
	localparam logic [7:0] REG_STATE      = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
	localparam logic [7:0] REG_OFFSETS    = 8'h10;

	localparam int CTRL_RT_MODE    = 0;
	localparam int CTRL_RT_RESTART = 1;
	localparam int IRQ_W           = 4;
	localparam int IRQ_MAIL_TO_B   = 0;
	localparam int IRQ_MAIL_TO_A   = 1;
	localparam int IRQ_FULL        = 2;
	localparam int IRQ_EMPTY       = 3;
	localparam int STATE_COUNT_LSB = 16;
	localparam int OFFSETS_Y_LSB   = 16;

endpackage

`default_nettype wire

// ### logic/dual_fifo_store.sv
// word array of the fifo: one write port, one combinational read port.
// assumes the caller never writes a location that is being read out.
`timescale 1ns/1ps
`default_nettype none

module dual_fifo_store
	import dual_fifo_pkg::*;
(
	// clock
	input  wire logic              i_clock,
	// write side
	input  wire logic              i_write,
	input  wire logic [ADDR_W-1:0] i_write_addr,
	input  wire logic [DATA_W-1:0] i_write_data,
	// read side
	input  wire logic [ADDR_W-1:0] i_read_addr,
	output logic      [DATA_W-1:0] o_read_data
);

	logic [DATA_W-1:0] words [DEPTH];

	// no reset: contents are undefined until written
	always_ff @(posedge i_clock) begin
		if (i_write) begin
			words[i_write_addr] <= i_write_data;
		end
	end

	assign o_read_data = words[i_read_addr];

endmodule

`default_nettype wire

// ### logic/flag_sync.sv
// two-stage flag synchroniser stepped by a port clock edge.
// a true level walks through both stages on steps; a false level
// clears both at once so a flag never claims room or data too late.
`timescale 1ns/1ps
`default_nettype none

module flag_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// level in, port edge step
	input  wire logic i_step,
	input  wire logic i_level,
	// synchronised level
	output logic      o_level
);

	logic stage;
	logic next_stage;
	logic next_level;

	always_comb begin
		next_stage = stage;
		next_level = o_level;
		if (!i_level) begin
			next_stage = 1'b0;
			next_level = 1'b0;
		end else if (i_step) begin
			next_stage = 1'b1;
			next_level = stage;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			stage   <= RESET_VALUE;
			o_level <= RESET_VALUE;
		end else begin
			stage   <= next_stage;
			o_level <= next_level;
		end
	end

endmodule

`default_nettype wire

// ### tb/port_host.sv
// far-side host model: a free-running port clock and the two-way data wire.
// assumes i_clock runs four times the port clock rate.
`timescale 1ns/1ps
`default_nettype none

module port_host
	import dual_fifo_pkg::*;
#(
	parameter logic [1:0] PHASE = 2'h0
) (
	// clock
	input  wire logic              i_clock,
	// port clock and data wire
	output logic                   o_port_clock,
	input  wire logic              i_dev_oe,
	input  wire logic [DATA_W-1:0] i_dev_data,
	input  wire logic              i_host_drive,
	input  wire logic [DATA_W-1:0] i_host_data,
	output logic      [DATA_W-1:0] o_bus
);
	logic [1:0]        div  = PHASE;
	logic [DATA_W-1:0] last = '0;

	// clock never stops between transfers
	assign o_port_clock = div[1];
	always_ff @(posedge i_clock) begin
		div <= div + 2'h1;
		if (i_dev_oe | i_host_drive)
			last <= o_bus;
	end
	// a released wire must not keep looking valid
	assign o_bus = i_dev_oe ? i_dev_data : (i_host_drive ? i_host_data : ~last);
endmodule

`default_nettype wire

// ### tb/tb_dual_fifo.sv
// self-checking bench for the dual-port fifo.
// assumes straps select preset offsets, then parallel load after a second reset,
// and port clocks run at a quarter rate.
`timescale 1ns/1ps
`default_nettype none

module tb_dual_fifo
	import dual_fifo_pkg::*;
;
	logic              i_clock = 1'b0, i_rst = 1'b1, pa_clk, pb_clk;
	logic              a_sel_n = 1'b1, a_en = 1'b0, a_wr = 1'b0, a_mb = 1'b0, a_drive = 1'b0;
	logic              b_sel_n = 1'b1, b_en = 1'b0, b_mb = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic              b_wr = 1'b0, b_drive = 1'b0, s_hi = 1'b0, s_lo = 1'b1;
	logic [DATA_W-1:0] a_host = '0, b_host = '0, a_bus, b_bus, a_out, b_out;
	logic              a_oe, b_oe, ir, af_n, ma_w, or_f, ae_n, mb_w, full, empty, irq, pready, perr, err;
	logic [7:0]        paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	int                bad_count = 0, check_count = 0;
	logic [DATA_W-1:0] rows [4][2] = '{'{36'h000000000, 36'h000000000}, '{36'hfffffffff, 36'hfffffffff},
		'{36'h5a5a5a5a5, 36'h5a5a5a5a5}, '{36'h800000001, 36'h800000001}};

	initial forever #2.5 i_clock = ~i_clock;

	port_host #(.PHASE(2'h0)) host_a (.i_clock(i_clock), .o_port_clock(pa_clk), .i_dev_oe(a_oe),
		.i_dev_data(a_out), .i_host_drive(a_drive), .i_host_data(a_host), .o_bus(a_bus));
	port_host #(.PHASE(2'h1)) host_b (.i_clock(i_clock), .o_port_clock(pb_clk), .i_dev_oe(b_oe),
		.i_dev_data(b_out), .i_host_drive(b_drive), .i_host_data(b_host), .o_bus(b_bus));

	dual_fifo dut (.i_clock(i_clock), .i_rst(i_rst), .i_write_side_clock(pa_clk),
		.i_side_a_select_n(a_sel_n), .i_side_a_master_enable(a_en), .i_side_a_write(a_wr),
		.i_side_a_mailbox_select(a_mb), .i_side_a_data_bus(a_bus), .o_side_a_data_bus(a_out),
		.o_side_a_data_bus_oe(a_oe), .o_input_ready_flag(ir), .o_almost_full_flag_n(af_n),
		.o_mail_to_a_waiting(ma_w), .i_read_side_clock(pb_clk), .i_side_b_select_n(b_sel_n),
		.i_side_b_master_enable(b_en), .i_side_b_write(b_wr), .i_side_b_mailbox_select(b_mb),
		.i_side_b_data_bus(b_bus), .o_side_b_data_bus(b_out), .o_side_b_data_bus_oe(b_oe),
		.o_output_ready_flag(or_f), .o_almost_empty_flag_n(ae_n), .o_mail_to_b_waiting(mb_w),
		.i_offset_select_hi_serial_enable(s_hi), .i_offset_select_lo_serial_bit(s_lo),
		.o_store_full(full), .o_store_empty(empty), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
		.o_irq(irq));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// called right after a rising edge; holds the request until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("apb_ready", 36'(pready), 36'h1);
		r = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge i_clock);
	endtask

	// controls held across one whole port clock high phase
	task automatic port_a(input logic wr, input logic mb, input logic en, input logic [DATA_W-1:0] d);
		@(negedge pa_clk);
		a_sel_n <= 1'b0;
		a_en <= en;
		a_wr <= wr;
		a_mb <= mb;
		a_host <= d;
		a_drive <= wr;
		@(negedge pa_clk);
		a_sel_n <= 1'b1;
		a_drive <= 1'b0;
	endtask

	task automatic port_b(input logic mb, output logic [DATA_W-1:0] r);
		@(negedge pb_clk);
		b_sel_n <= 1'b0;
		b_en <= 1'b1;
		b_mb <= mb;
		@(negedge pb_clk);
		b_sel_n <= 1'b1;
		// taken off the host wire, so the output enable is checked too
		@(posedge i_clock);
		r = b_bus;
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		int n;
		logic [DATA_W-1:0] r;
		repeat (16) @(posedge i_clock);
		check("ir_in_reset", 36'(ir), 36'h0);
		check("empty_in_reset", 36'(empty), 36'h1);
		i_rst <= 1'b0;
		for (n = 0; n < 200 && ir !== 1'b1; n++) @(posedge i_clock);
		check("ir_after_config", 36'(ir), 36'h1);
		apb(1'b0, REG_OFFSETS, '0, rd);
		check("offsets", 36'(rd), 36'({6'h0, PRESET_HI, 6'h0, PRESET_HI}));
		port_a(1'b1, 1'b0, 1'b0, 36'h123456789);
		repeat (12) @(posedge i_clock);
		check("disabled_write", 36'(empty), 36'h1);
		foreach (rows[i]) port_a(1'b1, 1'b0, 1'b1, rows[i][0]);
		for (n = 0; n < 200 && or_f !== 1'b1; n++) @(posedge i_clock);
		check("almost_empty", 36'(ae_n), 36'h0);
		check("almost_full", 36'(af_n), 36'h1);
		foreach (rows[i]) begin
			port_b(1'b0, r);
			check("fifo_word", r, rows[i][1]);
		end
		port_b(1'b0, r);
		check("read_when_empty", r, rows[3][1]);
		check("empty_after_drain", 36'(empty), 36'h1);
		// only mail to b may interrupt
		apb(1'b1, REG_IRQ_MASK, 32'h1, rd);
		apb(1'b1, REG_IRQ_STATUS, 32'hf, rd);
		port_a(1'b1, 1'b1, 1'b1, 36'hcafe01234);
		repeat (2) @(posedge i_clock);
		check("mail_waiting", 36'(mb_w), 36'h1);
		check("irq_raised", 36'(irq), 36'h1);
		apb(1'b0, REG_IRQ_STATUS, '0, rd);
		check("irq_status", 36'(rd[3:0]), 36'h1);
		apb(1'b1, REG_IRQ_MASK, 32'h0, rd);
		check("irq_masked", 36'(irq), 36'h0);
		port_b(1'b1, r);
		check("mail_word", r, 36'hcafe01234);
		repeat (2) @(posedge i_clock);
		check("mail_taken", 36'(mb_w), 36'h0);
		apb(1'b1, REG_IRQ_STATUS, 32'h1, rd);
		apb(1'b1, REG_IRQ_MASK, 32'h1, rd);
		check("irq_cleared", 36'(irq), 36'h0);
		apb(1'b0, 8'h40, '0, rd);
		check("unmapped_err", 36'(err), 36'h1);
		// mailbox b to a; host b drives its wire only while writing
		b_wr <= 1'b1;
		b_drive <= 1'b1;
		b_host <= 36'h9abc0def1;
		port_b(1'b1, r);
		b_wr <= 1'b0;
		b_drive <= 1'b0;
		repeat (2) @(posedge i_clock);
		check("mail_a_waiting", 36'(ma_w), 36'h1);
		port_a(1'b0, 1'b1, 1'b1, '0);
		check("mail_a_word", a_bus, 36'h9abc0def1);
		repeat (2) @(posedge i_clock);
		check("mail_a_taken", 36'(ma_w), 36'h0);
		// second reset in mid-run, offsets loaded over port a
		s_lo <= 1'b0;
		i_rst <= 1'b1;
		repeat (4) @(posedge i_clock);
		check("ir_in_reset2", 36'(ir), 36'h0);
		i_rst <= 1'b0;
		port_a(1'b1, 1'b0, 1'b1, 36'h000000005);
		check("ir_wait_load", 36'(ir), 36'h0);
		port_a(1'b1, 1'b0, 1'b1, 36'h0000003ff);
		for (n = 0; n < 200 && ir !== 1'b1; n++) @(posedge i_clock);
		apb(1'b0, REG_OFFSETS, '0, rd);
		check("offsets_parallel", 36'(rd), 36'h003ff0005);
		// retransmit: mark at read pointer 0, read, rewind, read again
		apb(1'b1, REG_CONTROL, 32'h1, rd);
		port_a(1'b1, 1'b0, 1'b1, 36'h777788889);
		repeat (2) @(posedge i_clock);
		check("almost_full_low", 36'(af_n), 36'h0);
		for (n = 0; n < 200 && or_f !== 1'b1; n++) @(posedge i_clock);
		port_b(1'b0, r);
		check("rt_first", r, 36'h777788889);
		apb(1'b1, REG_CONTROL, 32'h3, rd);
		for (n = 0; n < 200 && or_f !== 1'b1; n++) @(posedge i_clock);
		check("rt_ready", 36'(or_f), 36'h1);
		port_b(1'b0, r);
		check("rt_word", r, 36'h777788889);
		stop_test();
	end

	initial begin
		#200us;
		bad_count++;
		stop_test();
	end
endmodule

`default_nettype wire
